// File: rtl/tsr_pkg.sv
// Constants, register map and state encoding of the temperature sensor register block.
// Assumes a 125 MHz system clock; shared by the design and its bench.
package tsr_pkg;
	// Register selector decode.
	localparam logic [2:0] SEL_TEMP = 3'h0;
	localparam logic [2:0] SEL_CFG = 3'h1;
	localparam logic [2:0] SEL_HYST = 3'h2;
	localparam logic [2:0] SEL_OTEMP = 3'h3;
	localparam logic [2:0] SEL_TRIG = 3'h4;
	// Power-on values.
	localparam logic [7:0] SELECTOR_RST = 8'h00;
	localparam logic [15:0] TEMP_RST = 16'h0000;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [15:0] HYST_RST = 16'h4b00;
	localparam logic [15:0] OTEMP_RST = 16'h5000;
	// Configuration fields.
	localparam int CFG_SHUTDOWN = 0;
	localparam int CFG_INT_MODE = 1;
	localparam int CFG_POLARITY = 2;
	localparam int CFG_QUEUE_LO = 3;
	localparam int CFG_QUEUE_HI = 4;
	localparam int CFG_ONE_SHOT = 5;
	// Fault counts selected by the queue field.
	localparam logic [2:0] QUEUE_N0 = 3'h1;
	localparam logic [2:0] QUEUE_N1 = 3'h2;
	localparam logic [2:0] QUEUE_N2 = 3'h4;
	localparam logic [2:0] QUEUE_N3 = 3'h6;
	// Serial address: fixed upper bits, then three pins.
	localparam logic [3:0] ADDR_FIXED = 4'h9;
	// Timing.
	localparam int CLK_KHZ = 125000;
	localparam int CONV_PERIOD_MS = 60;
	localparam int CONV_CYCLES = CONV_PERIOD_MS * CLK_KHZ;
	localparam int TIMEOUT_MS = 25;
	localparam int TIMEOUT_CYCLES = TIMEOUT_MS * CLK_KHZ;
	// Serial engine states.
	typedef enum logic [6:0] {
		ST_IDLE = 7'b0000001,
		ST_ADDR = 7'b0000010,
		ST_ADDR_ACK = 7'b0000100,
		ST_WR_BYTE = 7'b0001000,
		ST_WR_ACK = 7'b0010000,
		ST_RD_BYTE = 7'b0100000,
		ST_RD_ACK = 7'b1000000
	} tsr_state_t;
endpackage

// File: rtl/tsr_top.sv
// Two-wire temperature sensor: serial slave, register bank, conversion timing and fault queue.
// Assumes scl and sda_i are already synchronous to clk and that adc_data holds the converter result.
// Notes on behaviour
// - A measurement beyond the active limit counts as a fault.
// - Output event only after the configured faults in a row; a clean sample restarts.
// - Configuration bits 4:3 pick 1, 2, 4 or 6 faults.
// - Selector is write-only; its low three bits pick the target register.
// - Selector is zero after reset, so reads start at the temperature.
// - Selector 0 temperature, 1 configuration, 2 hysteresis, 3 over-temperature, 4 trigger.
// - Selector, configuration, trigger are 8 bits; temperature and limits are 16.
// - Temperature is read-only; writes to it change nothing.
// - Reset values: temperature 0x0000, config 0x00, hysteresis 0x4b00, limit 0x5000.
// - Temperature is two's complement with the sign in bit 15.
// - Sixteen-bit registers are sent high byte first, then low byte.
// - With one-shot mode and shutdown both clear a conversion starts every 60 ms.
// - In one-shot mode each trigger write runs exactly one conversion.
// - Configuration bit 2 sets output polarity: 0 active low, 1 active high.
// - Configuration bit 1 picks comparator (0) or interrupt (1) mode.
// - Shutdown stops periodic conversions, but one-shot trigger writes still convert; the serial registers stay reachable.
// - Bus address is 1001 plus the three address pins, sampled continuously.
// - Limit writes carry two data bytes, configuration writes one.
// - With no data-line activity for the timeout the slave releases and idles.
`timescale 1ns/1ps
`default_nettype none
module tsr_top #(
	parameter int CONV_CYCLES = tsr_pkg::CONV_CYCLES,
	parameter int TIMEOUT_CYCLES = tsr_pkg::TIMEOUT_CYCLES
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic scl,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic addr_pin2,
	input wire logic addr_pin1,
	input wire logic addr_pin0,
	input wire logic [11:0] adc_data,
	output logic adc_power,
	output logic over_limit_output
);
	tsr_pkg::tsr_state_t state_reg, state_next;
	logic scl_prev_reg, sda_prev_reg;
	logic [7:0] shift_reg, shift_next;
	logic [3:0] bit_cnt_reg, bit_cnt_next;
	logic [1:0] byte_idx_reg, byte_idx_next;
	logic rw_reg, rw_next;
	logic nack_reg, nack_next;
	logic sda_oe_reg, sda_oe_next;
	logic [7:0] selector_reg;
	logic [7:0] cfg_reg;
	logic [7:0] trig_reg;
	logic [15:0] temp_reg, hyst_reg, otemp_reg;
	logic [7:0] hi_byte_reg;
	logic [31:0] conv_cnt_reg;
	logic [31:0] idle_cnt_reg;
	logic [2:0] fault_cnt_reg;
	logic hunt_high_reg;
	logic active_reg;
	logic out_reg;
	logic power_reg;

	// Bus conditions.
	wire scl_rise = scl & ~scl_prev_reg;
	wire scl_fall = ~scl & scl_prev_reg;
	wire start_cond = scl & scl_prev_reg & sda_prev_reg & ~sda_i;
	wire stop_cond = scl & scl_prev_reg & ~sda_prev_reg & sda_i;
	wire timeout = (state_reg != tsr_pkg::ST_IDLE) && (idle_cnt_reg >= 32'(TIMEOUT_CYCLES - 1));
	wire [6:0] my_addr = {tsr_pkg::ADDR_FIXED, addr_pin2, addr_pin1, addr_pin0};
	wire addr_hit = (shift_reg[7:1] == my_addr);
	wire [2:0] sel = selector_reg[2:0];
	wire byte_done = scl_fall && (bit_cnt_reg == 4'h8);

	// Write commit: byte 0 goes to the selector, later bytes to the selected register.
	wire wr_commit = (state_reg == tsr_pkg::ST_WR_BYTE) && byte_done;
	wire wr_sel = wr_commit && (byte_idx_reg == 2'h0);
	wire wr_cfg = wr_commit && (byte_idx_reg == 2'h1) && (sel == tsr_pkg::SEL_CFG);
	wire wr_trig = wr_commit && (byte_idx_reg == 2'h1) && (sel == tsr_pkg::SEL_TRIG);
	wire wr_hi = wr_commit && (byte_idx_reg == 2'h1);
	wire wr_lo = wr_commit && (byte_idx_reg == 2'h2);
	wire wr_hyst = wr_lo && (sel == tsr_pkg::SEL_HYST);
	wire wr_otemp = wr_lo && (sel == tsr_pkg::SEL_OTEMP);
	// A read of any register is taken at the address acknowledge of a read transfer.
	wire rd_start = (state_reg == tsr_pkg::ST_ADDR_ACK) && scl_fall && rw_reg;

	// Read data: sixteen-bit registers give the high byte on even bytes, low byte on odd ones.
	wire is_wide = (sel == tsr_pkg::SEL_TEMP) || (sel == tsr_pkg::SEL_HYST) || (sel == tsr_pkg::SEL_OTEMP);
	wire [15:0] wide_val = (sel == tsr_pkg::SEL_TEMP) ? temp_reg :
		(sel == tsr_pkg::SEL_HYST) ? hyst_reg : otemp_reg;
	wire [7:0] narrow_val = (sel == tsr_pkg::SEL_CFG) ? cfg_reg :
		(sel == tsr_pkg::SEL_TRIG) ? trig_reg : 8'h00;
	wire [7:0] rd_byte_hi = is_wide ? wide_val[15:8] : narrow_val;
	wire [7:0] rd_byte_lo = is_wide ? wide_val[7:0] : narrow_val;

	always_comb begin
		state_next = state_reg;
		shift_next = shift_reg;
		bit_cnt_next = bit_cnt_reg;
		byte_idx_next = byte_idx_reg;
		rw_next = rw_reg;
		nack_next = nack_reg;
		sda_oe_next = sda_oe_reg;
		if (stop_cond || timeout) begin
			state_next = tsr_pkg::ST_IDLE;
			sda_oe_next = 1'b0;
		end else if (start_cond) begin
			state_next = tsr_pkg::ST_ADDR;
			bit_cnt_next = 4'h0;
			byte_idx_next = 2'h0;
			sda_oe_next = 1'b0;
		end else begin
			unique case (state_reg)
				tsr_pkg::ST_IDLE: begin
					sda_oe_next = 1'b0;
				end
				tsr_pkg::ST_ADDR, tsr_pkg::ST_WR_BYTE: begin
					if (scl_rise) begin
						shift_next = {shift_reg[6:0], sda_i};
						bit_cnt_next = bit_cnt_reg + 4'h1;
					end
					if (byte_done && state_reg == tsr_pkg::ST_ADDR) begin
						if (addr_hit) begin
							state_next = tsr_pkg::ST_ADDR_ACK;
							rw_next = shift_reg[0];
							sda_oe_next = 1'b1;
						end else begin
							state_next = tsr_pkg::ST_IDLE;
						end
					end else if (byte_done) begin
						state_next = tsr_pkg::ST_WR_ACK;
						sda_oe_next = 1'b1;
						if (byte_idx_reg != 2'h3) begin
							byte_idx_next = byte_idx_reg + 2'h1;
						end
					end
				end
				tsr_pkg::ST_ADDR_ACK: begin
					if (scl_fall) begin
						bit_cnt_next = 4'h0;
						if (rw_reg) begin
							state_next = tsr_pkg::ST_RD_BYTE;
							shift_next = rd_byte_hi;
							sda_oe_next = ~rd_byte_hi[7];
						end else begin
							state_next = tsr_pkg::ST_WR_BYTE;
							sda_oe_next = 1'b0;
						end
					end
				end
				tsr_pkg::ST_WR_ACK: begin
					if (scl_fall) begin
						state_next = tsr_pkg::ST_WR_BYTE;
						bit_cnt_next = 4'h0;
						sda_oe_next = 1'b0;
					end
				end
				tsr_pkg::ST_RD_BYTE: begin
					if (scl_fall) begin
						if (bit_cnt_reg == 4'h7) begin
							state_next = tsr_pkg::ST_RD_ACK;
							sda_oe_next = 1'b0;
						end else begin
							shift_next = {shift_reg[6:0], 1'b0};
							bit_cnt_next = bit_cnt_reg + 4'h1;
							sda_oe_next = ~shift_reg[6];
						end
					end
				end
				tsr_pkg::ST_RD_ACK: begin
					if (scl_rise) begin
						nack_next = sda_i;
					end
					if (scl_fall) begin
						if (nack_reg) begin
							state_next = tsr_pkg::ST_IDLE;
						end else begin
							state_next = tsr_pkg::ST_RD_BYTE;
							bit_cnt_next = 4'h0;
							byte_idx_next = byte_idx_reg ^ 2'h1;
							shift_next = byte_idx_reg[0] ? rd_byte_hi : rd_byte_lo;
							sda_oe_next = byte_idx_reg[0] ? ~rd_byte_hi[7] : ~rd_byte_lo[7];
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= tsr_pkg::ST_IDLE;
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
			shift_reg <= 8'h00;
			bit_cnt_reg <= 4'h0;
			byte_idx_reg <= 2'h0;
			rw_reg <= 1'b0;
			nack_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			scl_prev_reg <= scl;
			sda_prev_reg <= sda_i;
			shift_reg <= shift_next;
			bit_cnt_reg <= bit_cnt_next;
			byte_idx_reg <= byte_idx_next;
			rw_reg <= rw_next;
			nack_reg <= nack_next;
			sda_oe_reg <= sda_oe_next;
		end
	end

	// Any data-line change restarts the stall timer.
	always_ff @(posedge clk) begin
		if (srst || state_reg == tsr_pkg::ST_IDLE || sda_i != sda_prev_reg) begin
			idle_cnt_reg <= 32'h0;
		end else begin
			idle_cnt_reg <= idle_cnt_reg + 32'h1;
		end
	end

	// Register bank; temperature has no host write path at all.
	always_ff @(posedge clk) begin
		if (srst) begin
			selector_reg <= tsr_pkg::SELECTOR_RST;
			cfg_reg <= tsr_pkg::CFG_RST;
			hyst_reg <= tsr_pkg::HYST_RST;
			otemp_reg <= tsr_pkg::OTEMP_RST;
			trig_reg <= 8'h00;
			hi_byte_reg <= 8'h00;
		end else begin
			if (wr_sel) begin
				selector_reg <= shift_reg;
			end
			if (wr_cfg) begin
				cfg_reg <= shift_reg;
			end
			if (wr_trig) begin
				trig_reg <= shift_reg;
			end
			if (wr_hi) begin
				hi_byte_reg <= shift_reg;
			end
			if (wr_hyst) begin
				hyst_reg <= {hi_byte_reg, shift_reg};
			end
			if (wr_otemp) begin
				otemp_reg <= {hi_byte_reg, shift_reg};
			end
		end
	end

	// Conversion timing.
	wire one_shot_mode = cfg_reg[tsr_pkg::CFG_ONE_SHOT];
	wire shutdown = cfg_reg[tsr_pkg::CFG_SHUTDOWN];
	wire running = ~one_shot_mode & ~shutdown;
	wire period_end = running && (conv_cnt_reg >= 32'(CONV_CYCLES - 1));
	wire conv_pulse = period_end || (one_shot_mode && wr_trig);

	always_ff @(posedge clk) begin
		if (srst || conv_pulse || !running) begin
			conv_cnt_reg <= 32'h0;
		end else begin
			conv_cnt_reg <= conv_cnt_reg + 32'h1;
		end
	end

	// Fault queue: hunt for the over limit, then for a drop below hysteresis.
	wire [15:0] sample = {adc_data, 4'h0};
	wire above_otemp = $signed(sample[15:4]) > $signed(otemp_reg[15:4]);
	wire below_hyst = $signed(sample[15:4]) < $signed(hyst_reg[15:4]);
	wire is_fault = hunt_high_reg ? above_otemp : below_hyst;
	logic [2:0] need;
	always_comb begin
		unique case (cfg_reg[tsr_pkg::CFG_QUEUE_HI:tsr_pkg::CFG_QUEUE_LO])
			2'h0: need = tsr_pkg::QUEUE_N0;
			2'h1: need = tsr_pkg::QUEUE_N1;
			2'h2: need = tsr_pkg::QUEUE_N2;
			2'h3: need = tsr_pkg::QUEUE_N3;
		endcase
	end
	wire trip = conv_pulse && is_fault && (fault_cnt_reg + 3'h1 == need);
	wire int_mode = cfg_reg[tsr_pkg::CFG_INT_MODE];

	always_ff @(posedge clk) begin
		if (srst) begin
			temp_reg <= tsr_pkg::TEMP_RST;
			fault_cnt_reg <= 3'h0;
			hunt_high_reg <= 1'b1;
			active_reg <= 1'b0;
		end else begin
			if (conv_pulse) begin
				temp_reg <= sample;
				fault_cnt_reg <= (is_fault && !trip) ? fault_cnt_reg + 3'h1 : 3'h0;
			end
			if (trip) begin
				hunt_high_reg <= ~hunt_high_reg;
			end
			// A trip in the cycle of a read wins over the read's clear.
			if (trip) begin
				active_reg <= int_mode ? 1'b1 : hunt_high_reg;
			end else if (int_mode && rd_start) begin
				active_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			out_reg <= 1'b1;
			power_reg <= 1'b1;
		end else begin
			out_reg <= cfg_reg[tsr_pkg::CFG_POLARITY] ? active_reg : ~active_reg;
			power_reg <= running | conv_pulse;
		end
	end

	assign sda_o = 1'b0;
	assign sda_oe = sda_oe_reg;
	assign adc_power = power_reg;
	assign over_limit_output = out_reg;

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	a_temp_read_only: assert property (wr_commit && sel == tsr_pkg::SEL_TEMP && !conv_pulse |=> $stable(temp_reg))
		else $error("temperature changed by a host write");
	a_queue_count: assert property (trip |-> fault_cnt_reg == need - 3'h1)
		else $error("output tripped at the wrong fault count");
	a_single_fault: assert property (cfg_reg[4:3] == 2'h0 && conv_pulse && is_fault |-> trip)
		else $error("single fault did not trip");
	a_clean_restart: assert property (conv_pulse && !is_fault |=> fault_cnt_reg == 3'h0)
		else $error("clean sample did not restart the queue");
	// The output register uses the polarity bit of the cycle before, so a polarity write must not trip this.
	a_out_polarity: assert property (##1 over_limit_output == ($past(cfg_reg[2]) ~^ $past(active_reg)))
		else $error("output polarity wrong");
	a_shutdown_quiet: assert property (shutdown && !one_shot_mode |-> !conv_pulse)
		else $error("conversion during shutdown");
	a_one_shot_once: assert property (one_shot_mode && !wr_trig |-> !conv_pulse)
		else $error("conversion without a trigger in one-shot mode");
	sequence s_addr_ack;
		state_reg == tsr_pkg::ST_ADDR && byte_done;
	endsequence
	a_addr_match: assert property (s_addr_ack ##1 state_reg == tsr_pkg::ST_ADDR_ACK |-> $past(addr_hit) && sda_oe)
		else $error("acknowledged a foreign address");
	a_cfg_write: assert property (wr_cfg |=> cfg_reg == $past(shift_reg))
		else $error("configuration write lost");
	a_high_first: assert property (rd_start && is_wide |=> shift_reg == $past(wide_val[15:8]))
		else $error("wide read did not start with the high byte");
	a_int_hold: assert property (int_mode && active_reg && !rd_start && !trip |=> active_reg)
		else $error("interrupt released without a read");
endmodule
`default_nettype wire

// File: rtl/tsr_unused_placeholder_none.sv
// Intentionally empty companion file; all logic lives in the top module.
// Assumes nothing.

// File: testbench/tsr_host.sv
// Bus master model that drives the sensor's two-wire port.
// Assumes the bench resolves the data wire with a pull-up and feeds it back on sda.
`timescale 1ns/1ps
`default_nettype none
module tsr_host (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_m,
	output logic rd_strobe,
	output logic [7:0] rd_byte
);
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
		rd_strobe = 1'b0;
		rd_byte = 8'h00;
	end
	// Four system clocks per bus clock level keeps well above the two-cycle minimum.
	task automatic half();
		repeat (4) @(negedge clk);
	endtask
	task automatic clk_bit(input logic b, output logic s);
		sda_m = b;
		half();
		scl = 1'b1;
		half();
		s = sda;
		scl = 1'b0;
	endtask
	task automatic send(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
		clk_bit(1'b1, s);
		ack = ~s;
	endtask
	task automatic recv(input logic last);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, s);
			rd_byte[i] = s;
		end
		clk_bit(last, s);
		rd_strobe = 1'b1;
		@(negedge clk);
		rd_strobe = 1'b0;
	endtask
	task automatic open(input logic [7:0] ab, output logic ok);
		sda_m = 1'b0;
		half();
		scl = 1'b0;
		send(ab, ok);
	endtask
	task automatic close();
		sda_m = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda_m = 1'b1;
		half();
	endtask
	task automatic write(input logic [6:0] a, input logic [7:0] sel, input logic [15:0] d, input int n,
			output logic ok);
		logic k;
		open({a, 1'b0}, ok);
		send(sel, k);
		ok = ok & k;
		if (n == 2) begin
			send(d[15:8], k);
			ok = ok & k;
		end
		if (n > 0) begin
			send(sel == 8'h01 ? {2'b00, d[5:0]} : d[7:0], k);
			ok = ok & k;
		end
		close();
	endtask
	// The last byte is refused so the slave lets go of the data line before the stop.
	task automatic read(input logic [6:0] a, input int n, output logic ok);
		open({a, 1'b1}, ok);
		if (ok) begin
			for (int i = 1; i <= n; i++) recv(i == n);
		end
		close();
	endtask
endmodule
`default_nettype wire

// File: testbench/test_temp_sensor_register_control.sv
// Self-checking bench of the sensor register block, driven through the bus master model.
// Assumes the design package and tsr_host are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_temp_sensor_register_control;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [2:0] pins = 3'h5;
	logic [6:0] dev = {tsr_pkg::ADDR_FIXED, 3'h5};
	logic [11:0] adc = 12'h000;
	logic sda_o, sda_oe, adc_power, olo, scl, sda_m, rd_strobe, ok, pol;
	logic [7:0] rd_byte;
	logic [7:0] exp_q[$];
	logic [15:0] lfsr = 16'h0029;
	int need[4] = '{1, 2, 4, 6};
	int fails = 0;
	int checks = 0;
	wire sda = sda_m & ~(sda_oe & ~sda_o);
	always #4 clk = ~clk;
	tsr_top #(.CONV_CYCLES(2000), .TIMEOUT_CYCLES(5000)) dut_u (.clk(clk), .srst(srst), .scl(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe), .addr_pin2(pins[2]), .addr_pin1(pins[1]), .addr_pin0(pins[0]),
		.adc_data(adc), .adc_power(adc_power), .over_limit_output(olo));
	tsr_host host_u (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m), .rd_strobe(rd_strobe), .rd_byte(rd_byte));
	function automatic logic [15:0] next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	always @(posedge clk) begin
		if (rd_strobe === 1'b1) begin
			if (exp_q.size() == 0) check("extra byte", 16'h0001, 16'h0000);
			else check("read byte", {8'h00, rd_byte}, {8'h00, exp_q.pop_front()});
		end
	end
	task automatic wr(input logic [2:0] sel, input logic [15:0] d, input int n);
		host_u.write(dev, {5'h00, sel}, d, n, ok);
		check("write ack", {15'h0000, ok}, 16'h0001);
	endtask
	task automatic rd(input logic [2:0] sel, input logic [15:0] exp, input int n);
		wr(sel, 16'h0000, 0);
		if (n == 2) exp_q.push_back(exp[15:8]);
		exp_q.push_back(exp[7:0]);
		host_u.read(dev, n, ok);
		check("read ack", {15'h0000, ok}, 16'h0001);
	endtask
	// The output level is judged a few cycles after the stop so its one-cycle lag has landed.
	task automatic alert(input logic act, input logic p);
		repeat (3) @(negedge clk);
		check("alert level", {15'h0000, olo}, {15'h0000, act ~^ p});
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		fails++;
		summarize();
	end
	initial begin
		repeat (20) @(negedge clk);
		srst = 1'b0;
		repeat (4) @(negedge clk);
		check("power", {15'h0000, adc_power}, 16'h0001);
		exp_q.push_back(tsr_pkg::TEMP_RST[15:8]);
		exp_q.push_back(tsr_pkg::TEMP_RST[7:0]);
		host_u.read(dev, 2, ok);
		check("first read ack", {15'h0000, ok}, 16'h0001);
		rd(tsr_pkg::SEL_CFG, {8'h00, tsr_pkg::CFG_RST}, 1);
		rd(tsr_pkg::SEL_HYST, tsr_pkg::HYST_RST, 2);
		rd(tsr_pkg::SEL_OTEMP, tsr_pkg::OTEMP_RST, 2);
		host_u.read(dev ^ 7'h01, 1, ok);
		check("foreign ack", {15'h0000, ok}, 16'h0000);
		pins = 3'h2;
		dev = {tsr_pkg::ADDR_FIXED, 3'h2};
		rd(tsr_pkg::SEL_CFG, 16'h0000, 1);
		for (int k = 0; k < 4; k++) begin
			pol = k[0];
			wr(tsr_pkg::SEL_CFG, {10'h000, 1'b1, 2'b00, pol, 2'b00}, 1);
			adc = 12'h100;
			wr(tsr_pkg::SEL_TRIG, 16'h0000, 1);
			alert(1'b0, pol);
			wr(tsr_pkg::SEL_CFG, {10'h000, 1'b1, k[1:0], pol, 2'b00}, 1);
			adc = 12'h600;
			for (int i = 1; i < need[k]; i++) wr(tsr_pkg::SEL_TRIG, 16'h0000, 1);
			alert(1'b0, pol);
			wr(tsr_pkg::SEL_TRIG, 16'h0000, 1);
			alert(1'b1, pol);
			check("one-shot power", {15'h0000, adc_power}, 16'h0000);
		end
		// A read first clears the level left by comparator mode, so the trip below must raise it afresh.
		wr(tsr_pkg::SEL_CFG, 16'h0022, 1);
		rd(tsr_pkg::SEL_CFG, 16'h0022, 1);
		alert(1'b0, 1'b0);
		adc = 12'h100;
		wr(tsr_pkg::SEL_TRIG, 16'h0000, 1);
		alert(1'b1, 1'b0);
		rd(tsr_pkg::SEL_CFG, 16'h0022, 1);
		alert(1'b0, 1'b0);
		wr(tsr_pkg::SEL_CFG, 16'h0001, 1);
		adc = 12'hf9c;
		wr(tsr_pkg::SEL_TEMP, 16'h1234, 2);
		repeat (2100) @(negedge clk);
		check("shutdown power", {15'h0000, adc_power}, 16'h0000);
		rd(tsr_pkg::SEL_TEMP, 16'h1000, 2);
		wr(tsr_pkg::SEL_CFG, 16'h0000, 1);
		repeat (2100) @(negedge clk);
		check("run power", {15'h0000, adc_power}, 16'h0001);
		rd(tsr_pkg::SEL_TEMP, {adc, 4'h0}, 2);
		for (int i = 0; i < 4; i++) begin
			lfsr = next(lfsr);
			wr(i[0] ? tsr_pkg::SEL_OTEMP : tsr_pkg::SEL_HYST, lfsr, 2);
			rd(i[0] ? tsr_pkg::SEL_OTEMP : tsr_pkg::SEL_HYST, lfsr, 2);
		end
		repeat (4) @(negedge clk);
		check("queue empty", 16'(exp_q.size()), 16'h0000);
		summarize();
	end
endmodule
`default_nettype wire
